// File: rtl/ftc_failure_manager.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - failures 1, 2 and 5 change no switch and no driver
// - failure 3 or 8 opens high ground switch, disables high driver
// - failure 4, 6 or 7 opens both low switches, disables low driver
// - detection of all eight types runs only in full or receive-only mode
// - receive-only: no transmit, rx dominant when tx or bus dominant
// - without faults rx follows the differential bus state
// - type 3 or 6 held for detect time selects single-wire reception
// - type 3 or 6 absent for recover time restores normal reception
// - type 4 or 7: rx dominant, then timeout turns low side off
// - type 4 or 7 absent for recover time restores differential mode
// - a separate sticky flag for each of eight failure types
// - any set flag raises the maskable interrupt request
// - recovered flag clears only on host read of its register
// - tx dominant over 2 ms disables drivers, receive only
// - over-temperature disables only transmitter output stages
// - host selects mode by command; device applies it
// - standby: drivers, receivers off; faults 3,4,7,8 watched; low term to battery
// - regulator undervoltage forces standby mode
module ftc_failure_manager #(
  parameter int unsigned HIGH_SHORT_DETECT_TIME = 1000,
  parameter int unsigned LOW_SHORT_DETECT_TIME = 1000,
  parameter int unsigned HIGH_SHORT_RECOVER_TIME = 1000,
  parameter int unsigned LOW_SHORT_RECOVER_TIME = 1000,
  parameter int unsigned LOW_FAULT_DETECT_TIME = 1000,
  parameter int unsigned LOW_FAULT_RECOVER_TIME = 1000,
  parameter int unsigned TX_STUCK_CYCLES = ftc_pkg::FTC_TX_STUCK_CYC
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic regulator_undervolt_in,
  input wire logic over_temp_in,
  input wire logic [7:0] fail_detect_in,
  input wire logic diff_rx_in,
  input wire logic high_rx_in,
  input wire logic low_rx_in,
  input wire logic tx_in,
  output logic rx_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic tx_high_en_out,
  output logic tx_low_en_out,
  output logic receivers_en_out,
  output logic high_term_ground_switch_out,
  output logic low_term_supply_switch_out,
  output logic low_term_battery_switch_out,
  output logic single_wire_out,
  output logic [3:0] error_status_high_out,
  output logic [3:0] error_status_low_out,
  input wire logic read_status_high_in,
  input wire logic read_status_low_in,
  output logic fail_irq_out,
  input wire logic irq_mask_in,
  output logic [1:0] mode_out
);

  // whole block state lives in one packed record
  // fault filters, watchdog, rx buffer, flags and registered outputs
  // a single register keeps reset handling in one place
  // every output port is read straight from this record
  typedef struct packed {
    logic [1:0] mode;
    ftc_pkg::ftc_fstate_t hs_st;
    ftc_pkg::ftc_fstate_t ls_st;
    ftc_pkg::ftc_fstate_t lf_st;
    logic [ftc_pkg::FTC_CNT_W-1:0] hs_cnt;
    logic [ftc_pkg::FTC_CNT_W-1:0] ls_cnt;
    logic [ftc_pkg::FTC_CNT_W-1:0] lf_cnt;
    logic [ftc_pkg::FTC_CNT_W-1:0] tx_cnt;
    logic tx_stuck;
    logic [7:0] flags;
    logic [1:0] buf_v;
    logic [1:0] buf_d;
    logic buf_wr;
    logic buf_rd;
    logic rx;
    logic rx_valid;
    logic tx_h;
    logic tx_l;
    logic rcv_en;
    logic sw1;
    logic sw2;
    logic sw3;
    logic single;
    logic irq;
  } ftc_state_t;

  ftc_state_t q, d;

  // filter counters share one width
  // the width covers the stuck transmit count at full rate
  // filter parameters above that width would never expire
  // so keep every filter constant below two to the counter width

  // filter state codes: ok, fault, recovering
  // recovering still counts as faulty for switches and drivers
  // a returning condition restarts the recovery count

  // one filter step: detect after det cycles, recover after rec cycles absent
  function automatic logic [ftc_pkg::FTC_CNT_W+1:0] filt_step(
      input logic [1:0] st, input logic [ftc_pkg::FTC_CNT_W-1:0] cnt,
      input logic cond, input int unsigned det, input int unsigned rec);
    logic [1:0] ns;
    logic [ftc_pkg::FTC_CNT_W-1:0] nc;
    ns = st;
    nc = '0;
    case (st)
      2'b00: begin
        if (cond) begin
          nc = cnt + 1'b1;
          if (32'(nc) >= det) begin
            ns = 2'b01;
            nc = '0;
          end
        end
      end
      2'b01, 2'b10: begin
        if (!cond) begin
          nc = cnt + 1'b1;
          ns = 2'b10;
          if (32'(nc) >= rec) begin
            ns = 2'b00;
            nc = '0;
          end
        end else begin
          ns = 2'b01;
        end
      end
      default: ns = 2'b00;
    endcase
    return {ns, nc};
  endfunction

  logic [ftc_pkg::FTC_CNT_W+1:0] hs_r, ls_r, lf_r;
  logic [7:0] act;
  logic det_en, std_det, full_det, low_off, high_off, bus_dom, rx_bit, push, pop;

  // next state of the whole block
  // order of work below:
  //   mode selection and undervoltage override
  //   masking of the raw fault inputs by mode
  //   three fault filters: high short, low short, low fault
  //   stuck dominant transmit watchdog
  //   driver enables and termination switches
  //   choice of the receive source
  //   two-entry receive buffer
  //   sticky flags and interrupt request
  // switch and driver outputs lag the filter state by one cycle
  // the interrupt follows the flags in the same cycle
  always_comb begin
    d = q;
    // undervoltage overrides host selection; otherwise apply command
    if (regulator_undervolt_in) begin
      d.mode = ftc_pkg::FTC_MODE_STANDBY;
    end else if (mode_sel_in == ftc_pkg::FTC_MODE_FULL ||
                 mode_sel_in == ftc_pkg::FTC_MODE_RX_ONLY) begin
      d.mode = mode_sel_in;
    end else begin
      d.mode = ftc_pkg::FTC_MODE_STANDBY;
    end
    full_det = (q.mode == ftc_pkg::FTC_MODE_FULL) || (q.mode == ftc_pkg::FTC_MODE_RX_ONLY);
    std_det = (q.mode == ftc_pkg::FTC_MODE_STANDBY);
    det_en = full_det || std_det;
    // standby only watches types 3, 4, 7 and 8
    act = '0;
    if (full_det) begin
      act = fail_detect_in;
    end else if (std_det) begin
      act[ftc_pkg::FTC_F3] = fail_detect_in[ftc_pkg::FTC_F3];
      act[ftc_pkg::FTC_F4] = fail_detect_in[ftc_pkg::FTC_F4];
      act[ftc_pkg::FTC_F7] = fail_detect_in[ftc_pkg::FTC_F7];
      act[ftc_pkg::FTC_F8] = fail_detect_in[ftc_pkg::FTC_F8];
    end
    // filtered fault states
    hs_r = filt_step(q.hs_st, q.hs_cnt, act[ftc_pkg::FTC_F3],
                     HIGH_SHORT_DETECT_TIME, HIGH_SHORT_RECOVER_TIME);
    ls_r = filt_step(q.ls_st, q.ls_cnt, act[ftc_pkg::FTC_F6],
                     LOW_SHORT_DETECT_TIME, LOW_SHORT_RECOVER_TIME);
    lf_r = filt_step(q.lf_st, q.lf_cnt, act[ftc_pkg::FTC_F4] | act[ftc_pkg::FTC_F7],
                     LOW_FAULT_DETECT_TIME, LOW_FAULT_RECOVER_TIME);
    d.hs_st = ftc_pkg::ftc_fstate_t'(hs_r[ftc_pkg::FTC_CNT_W+1:ftc_pkg::FTC_CNT_W]);
    d.hs_cnt = hs_r[ftc_pkg::FTC_CNT_W-1:0];
    d.ls_st = ftc_pkg::ftc_fstate_t'(ls_r[ftc_pkg::FTC_CNT_W+1:ftc_pkg::FTC_CNT_W]);
    d.ls_cnt = ls_r[ftc_pkg::FTC_CNT_W-1:0];
    d.lf_st = ftc_pkg::ftc_fstate_t'(lf_r[ftc_pkg::FTC_CNT_W+1:ftc_pkg::FTC_CNT_W]);
    d.lf_cnt = lf_r[ftc_pkg::FTC_CNT_W-1:0];
    // type 8 has no filter, acted on while present
    high_off = (q.hs_st != ftc_pkg::FTC_FS_OK) || act[ftc_pkg::FTC_F8];
    low_off = (q.ls_st != ftc_pkg::FTC_FS_OK) || (q.lf_st != ftc_pkg::FTC_FS_OK);
    // stuck dominant transmit watchdog, dominant is low
    if (!tx_in && q.mode == ftc_pkg::FTC_MODE_FULL) begin
      if (32'(q.tx_cnt) >= TX_STUCK_CYCLES) begin
        d.tx_stuck = 1'b1;
      end else begin
        d.tx_cnt = q.tx_cnt + 1'b1;
      end
    end else begin
      d.tx_cnt = '0;
      d.tx_stuck = 1'b0;
    end
    // drivers: types 1, 2, 5 leave them alone
    d.tx_h = (q.mode == ftc_pkg::FTC_MODE_FULL) && !q.tx_stuck && !over_temp_in &&
             !high_off;
    d.tx_l = (q.mode == ftc_pkg::FTC_MODE_FULL) && !q.tx_stuck && !over_temp_in &&
             !low_off;
    d.rcv_en = !std_det;
    // switches closed = 1
    d.sw1 = !high_off;
    d.sw2 = !low_off && !std_det;
    d.sw3 = !low_off;
    d.single = high_off || low_off;
    // reception source: unfiltered 4/7 first shows as dominant
    if (std_det) begin
      bus_dom = 1'b0;
    end else if (q.lf_st != ftc_pkg::FTC_FS_OK) begin
      bus_dom = !high_rx_in;
    end else if (act[ftc_pkg::FTC_F4] | act[ftc_pkg::FTC_F7]) begin
      bus_dom = 1'b1;
    end else if (q.hs_st != ftc_pkg::FTC_FS_OK) begin
      bus_dom = !low_rx_in;
    end else if (q.ls_st != ftc_pkg::FTC_FS_OK) begin
      bus_dom = !high_rx_in;
    end else begin
      bus_dom = !diff_rx_in;
    end
    if (q.mode == ftc_pkg::FTC_MODE_RX_ONLY) begin
      bus_dom = bus_dom || !tx_in;
    end
    rx_bit = !bus_dom;
    // two-entry buffer; the receiver may stall without loss while room remains
    push = 1'b1;
    pop = q.rx_valid && rx_ready_in;
    d.buf_v = q.buf_v;
    d.buf_d = q.buf_d;
    d.buf_rd = q.buf_rd;
    d.buf_wr = q.buf_wr;
    if (pop) begin
      d.buf_v[q.buf_rd] = 1'b0;
      d.buf_rd = !q.buf_rd;
    end
    if (push && (!q.buf_v[q.buf_wr] || pop && q.buf_wr == q.buf_rd)) begin
      d.buf_v[q.buf_wr] = 1'b1;
      d.buf_d[q.buf_wr] = rx_bit;
      d.buf_wr = !q.buf_wr;
    end
    d.rx_valid = d.buf_v[d.buf_rd];
    d.rx = d.buf_v[d.buf_rd] ? d.buf_d[d.buf_rd] : ftc_pkg::FTC_RX_RECESSIVE;
    // sticky flags: set wins over read clear, clear only once recovered
    for (int i = 0; i < ftc_pkg::FTC_NUM_FAIL; i++) begin
      if (act[i] && det_en) begin
        d.flags[i] = 1'b1;
      end else if ((i < 4 ? read_status_low_in : read_status_high_in)) begin
        d.flags[i] = 1'b0;
      end
    end
    d.irq = (|d.flags) && !irq_mask_in;
  end

  // reset state: standby, drivers off, high switch closed
  // low termination held to battery, as in standby
  // receive output parked recessive with no valid entry

  // single state register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      q <= '0;
      q.rx <= 1'b1;
      q.sw1 <= 1'b1;
      q.sw2 <= 1'b0;
      q.sw3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs taken straight from the state register
  // no logic between flops and pins, so no glitches reach them
  assign rx_out = q.rx;
  assign rx_valid_out = q.rx_valid;
  assign tx_high_en_out = q.tx_h;
  assign tx_low_en_out = q.tx_l;
  assign receivers_en_out = q.rcv_en;
  assign high_term_ground_switch_out = q.sw1;
  assign low_term_supply_switch_out = q.sw2;
  assign low_term_battery_switch_out = q.sw3;
  assign single_wire_out = q.single;
  assign error_status_low_out = q.flags[3:0];
  assign error_status_high_out = q.flags[7:4];
  assign fail_irq_out = q.irq;
  assign mode_out = q.mode;

endmodule // ftc_failure_manager
`default_nettype wire

// File: pkg/ftc_pkg.sv
`default_nettype none
package ftc_pkg;
  // transceiver modes selected by the host
  typedef enum logic [1:0] {
    FTC_MODE_STANDBY = 2'b00,
    FTC_MODE_FULL = 2'b01,
    FTC_MODE_RX_ONLY = 2'b10
  } ftc_mode_t;
  // per-wire fault handling state
  typedef enum logic [1:0] {
    FTC_FS_OK = 2'b00,
    FTC_FS_FAULT = 2'b01,
    FTC_FS_RECOVER = 2'b10
  } ftc_fstate_t;
  localparam int unsigned FTC_CLK_MHZ = 250;
  localparam int unsigned FTC_TX_STUCK_US = 2000;
  localparam int unsigned FTC_TX_STUCK_CYC = FTC_TX_STUCK_US * FTC_CLK_MHZ;
  localparam int unsigned FTC_CNT_W = 20;
  localparam int unsigned FTC_NUM_FAIL = 8;
  // fault bit positions (type n at index n-1)
  localparam int unsigned FTC_F3 = 2;
  localparam int unsigned FTC_F4 = 3;
  localparam int unsigned FTC_F6 = 5;
  localparam int unsigned FTC_F7 = 6;
  localparam int unsigned FTC_F8 = 7;
  localparam logic [3:0] FTC_ERR_RESET = 4'h0;
  localparam logic FTC_RX_RECESSIVE = 1'b1;
endpackage
`default_nettype wire

// File: sim/ftc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ftc_monitor (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] mode_out,
  input wire logic regulator_undervolt_in,
  input wire logic over_temp_in,
  input wire logic irq_mask_in,
  input wire logic read_status_low_in,
  input wire logic tx_high_en_out,
  input wire logic tx_low_en_out,
  input wire logic receivers_en_out,
  input wire logic high_term_ground_switch_out,
  input wire logic low_term_supply_switch_out,
  input wire logic low_term_battery_switch_out,
  input wire logic single_wire_out,
  input wire logic [3:0] error_status_low_out,
  input wire logic [3:0] error_status_high_out,
  input wire logic fail_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // an open switch must never leave its driver fighting the short
  property p_hi; !high_term_ground_switch_out |-> !tx_high_en_out; endproperty
  a_hi: assert property (p_hi) else $error("high driver on");
  property p_lo; !low_term_battery_switch_out |-> !low_term_supply_switch_out && !tx_low_en_out;
  endproperty
  a_lo: assert property (p_lo) else $error("low side not off");
  property p_stby; (mode_out == ftc_pkg::FTC_MODE_STANDBY)[*2] |=>
    !$rose(error_status_low_out[0]) && !$rose(error_status_high_out[1]); endproperty
  a_stby: assert property (p_stby) else $error("flag set in standby");
  property p_rxo; (mode_out == ftc_pkg::FTC_MODE_RX_ONLY)[*3] |-> !tx_high_en_out && !tx_low_en_out;
  endproperty
  a_rxo: assert property (p_rxo) else $error("driver on in rx-only");
  property p_hot; over_temp_in[*3] |-> !tx_high_en_out && !tx_low_en_out; endproperty
  a_hot: assert property (p_hot) else $error("driver on while hot");
  property p_uv; regulator_undervolt_in[*3] |->
    mode_out == ftc_pkg::FTC_MODE_STANDBY && !receivers_en_out; endproperty
  a_uv: assert property (p_uv) else $error("not standby on undervoltage");
  property p_irq; fail_irq_out |-> |{error_status_high_out, error_status_low_out} && !$past(irq_mask_in);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  property p_clr; |($past(error_status_low_out) & ~error_status_low_out) |->
    $past(read_status_low_in); endproperty
  a_clr: assert property (p_clr) else $error("flag cleared without read");
  // main scenarios reached
  c_sw: cover property ($rose(single_wire_out));
  c_clr: cover property ($fell(error_status_low_out[2]));
  c_irq: cover property ($rose(fail_irq_out));
endmodule // ftc_monitor
`default_nettype wire

// File: sim/ftc_can_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ftc_can_partner (
  input wire logic tx_bit_in,
  input wire logic far_dom_in,
  input wire logic stall_in,
  input wire logic tx_high_en_in,
  input wire logic tx_low_en_in,
  output logic tx_out,
  output logic diff_rx_out,
  output logic high_rx_out,
  output logic low_rx_out,
  output logic ready_out
);
  logic dom;
  // wired bus: dominant when this node drives or another node does
  assign dom = (!tx_bit_in && (tx_high_en_in || tx_low_en_in)) || far_dom_in;
  assign tx_out = tx_bit_in;
  assign diff_rx_out = !dom;
  assign high_rx_out = !dom;
  assign low_rx_out = !dom;
  assign ready_out = !stall_in; // controller may stall reception
endmodule // ftc_can_partner
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] msel = 2'h0;
  logic uv = 1'b0, hot = 1'b0, mask = 1'b0, rd = 1'b0, txb = 1'b1, fdom = 1'b0, stall = 1'b0;
  logic [7:0] fail = 8'h00;
  logic rx, rxv, txh, txl, rxen, s1, s2, s3, sw, irq, tx, dif, hi, lo, rdy;
  logic [3:0] esh, esl;
  logic [1:0] mo;
  int mismatches = 0;
  int check_count = 0;
  always #2 clk_in = ~clk_in;
  ftc_can_partner u_can (.tx_bit_in(txb), .far_dom_in(fdom), .stall_in(stall),
    .tx_high_en_in(txh), .tx_low_en_in(txl), .tx_out(tx), .diff_rx_out(dif),
    .high_rx_out(hi), .low_rx_out(lo), .ready_out(rdy));
  // short filters keep the run brief
  // low fault filter keeps its default length, so types 4 and 7 see the real timeout
  ftc_failure_manager #(.HIGH_SHORT_DETECT_TIME(4), .LOW_SHORT_DETECT_TIME(4),
    .HIGH_SHORT_RECOVER_TIME(4), .LOW_SHORT_RECOVER_TIME(4),
    .TX_STUCK_CYCLES(20)) dut (.clk_in, .reset_in,
    .mode_sel_in(msel), .regulator_undervolt_in(uv), .over_temp_in(hot), .fail_detect_in(fail),
    .diff_rx_in(dif), .high_rx_in(hi), .low_rx_in(lo), .tx_in(tx), .rx_out(rx),
    .rx_valid_out(rxv), .rx_ready_in(rdy), .tx_high_en_out(txh), .tx_low_en_out(txl),
    .receivers_en_out(rxen), .high_term_ground_switch_out(s1), .low_term_supply_switch_out(s2),
    .low_term_battery_switch_out(s3), .single_wire_out(sw), .error_status_high_out(esh),
    .error_status_low_out(esl), .read_status_high_in(rd), .read_status_low_in(rd),
    .fail_irq_out(irq), .irq_mask_in(mask), .mode_out(mo));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // host read pulse, then flags must be gone
  task automatic t_read;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(2);
    chk({esh, esl}, 8'h00);
  endtask
  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      msel = m[1:0];
      cyc(3);
      chk(8'(mo), (m == 1 || m == 2) ? 8'(m) : 8'h00);
      chk(8'(rxen), 8'(m == 1 || m == 2));
    end
    msel = 2'h1;
    uv = 1'b1;
    cyc(3);
    chk(8'(mo), 8'h00);
    uv = 1'b0;
    cyc(3);
  endtask
  // single fault: flag, switch action, recovery, sticky until read
  task automatic t_fault(input int n, input logic hs, input logic ls, input logic swe);
    int i;
    fail = 8'h01 << (n - 1);
    for (i = 0; i < 1100 && swe && sw !== 1'b1; i++) cyc(1);
    if (i == 1100) begin
      mismatches++;
      give_verdict();
    end
    cyc(12);
    chk({esh, esl}, fail);
    chk(8'(irq), 8'h01);
    chk({s1, txh}, {6'h0, !hs, !hs});
    chk({s2, s3, txl}, {5'h0, !ls, !ls, !ls});
    chk(8'(sw), 8'(swe));
    fail = 8'h00;
    cyc(1010);
    chk({s1, s2, s3, sw}, 8'h0e);
    mask = 1'b1;
    cyc(2);
    chk({irq, esh, esl}, {1'b0, 8'h01 << (n - 1)});
    mask = 1'b0;
    t_read();
  endtask
  task automatic t_misc;
    msel = 2'h0;
    cyc(2);
    fail = 8'h01;
    cyc(6);
    chk({esh, esl, s2, s3}, 8'h01);
    fail = 8'h04;
    cyc(4);
    chk({esh, esl}, 8'h04);
    fail = 8'h00;
    t_read();
    msel = 2'h1;
    txb = 1'b0;
    cyc(30);
    chk({txh, txl}, 8'h00);
    txb = 1'b1;
    hot = 1'b1;
    cyc(4);
    chk({txh, txl, rxen}, 8'h01);
    hot = 1'b0;
    fdom = 1'b1;
    cyc(4);
    chk({txh, txl, rxv, rx}, 8'h0e);
    stall = 1'b1;
    fdom = 1'b0;
    cyc(4);
    chk({rxv, rx}, 8'h02);
    stall = 1'b0;
    cyc(4);
    chk({rxv, rx}, 8'h03);
    msel = 2'h2;
    txb = 1'b0;
    cyc(4);
    chk({txh, txl, rxv, rx}, 8'h02);
  endtask
  // main sequence
  initial begin
    cyc(4);
    reset_in = 1'b0;
    t_mode();
    for (int n = 1; n <= 8; n++) t_fault(n, 8'h84 >> (n - 1), 8'h68 >> (n - 1), 8'hec >> (n - 1));
    t_misc();
    give_verdict();
  end
endmodule // tb_top
bind ftc_failure_manager ftc_monitor u_mon (.clk_in, .reset_in, .mode_out,
  .regulator_undervolt_in, .over_temp_in, .irq_mask_in, .read_status_low_in, .tx_high_en_out,
  .tx_low_en_out, .receivers_en_out, .high_term_ground_switch_out, .low_term_supply_switch_out,
  .low_term_battery_switch_out, .single_wire_out, .error_status_low_out, .error_status_high_out,
  .fail_irq_out);
`default_nettype wire
